// file: core/gpp_port.v
// gpio pin port: direction, drive level, sensing and register access
// Operation
// - after reset all pads are inputs with input buffers enabled
// - one direction and one drive bit per pin; direction one drives
// - direction set strobe sets only the written one bits
// - direction clear strobe clears only the written one bits
// - direction toggle strobe inverts only the written one bits
// - drive set strobe sets the matching drive bits to one
// - drive clear strobe forces the matching drive bits to zero
// - writing ones to drive toggle or input value inverts drive bits
// - input value is synchronised; synchroniser stops when input disabled
// - pin level is readable whether pin is input or output
// - pin n configuration byte sits at offset 0x10 plus n
// - inversion bit inverts both driven and sensed value
// - changing inversion makes an edge seen by sense logic
// - pull-up is on while the pull-up bit is one
// - sense field picks both, rising, falling, low level or disabled
// - inversion change with sense change may lose the edge
// - pending interrupt may fire when input is re-enabled
// - sense change during synchronisation may discard the interrupt
// - async pins wake on any sense; others on both edges or level while clock stopped, else any sense
// - mirrored view of dir, out, in and flags behaves the same
// - debug mode does not alter port behaviour
// - interrupt stays asserted while flag set and sense enabled
// - non-async pins accept no new interrupt within three cycles
// - event output follows pin while input enabled, else zero
// - reading direction set location returns the direction register
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "gpp_map.vh"

module gpp_port #(
	parameter NPIN = 8,
	parameter [7:0] ASYNC_PINS = 8'h04
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst,
	// register port
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	// system state
	input wire i_sleep_clk_stopped,
	// pads
	input wire [NPIN-1:0] i_pad,
	output wire [NPIN-1:0] o_pad,
	output wire [NPIN-1:0] o_pad_oe_n,
	output wire [NPIN-1:0] o_pullup,
	output wire [NPIN-1:0] o_inbuf_en,
	// events, interrupt and wake
	output wire [NPIN-1:0] o_event,
	output wire o_irq,
	output wire o_wake
);

	// ************************************************************
	// register state
	// ************************************************************
	reg [NPIN-1:0] dir_q;
	reg [NPIN-1:0] out_q;
	reg [NPIN-1:0] flag_q;
	reg [7:0] cfg_q [0:NPIN-1];
	reg [NPIN-1:0] sync1_q;
	reg [NPIN-1:0] sync2_q;
	reg [NPIN-1:0] prev_q;
	reg [NPIN-1:0] pend_q;
	wire [NPIN-1:0] in_val;
	wire [NPIN-1:0] hit;
	wire [NPIN-1:0] inv;
	wire [NPIN-1:0] in_en;
	wire [NPIN-1:0] sense_en;
	wire [NPIN-1:0] wake_pin;
	wire [NPIN-1:0] set_hit;
	wire [NPIN-1:0] dead;

	// decode of writes; the mirrored view aliases the same registers
	wire [7:0] reg_off = (i_addr >= `GPP_MIR_BASE &&
		i_addr < `GPP_MIR_BASE + 8'h04) ?
		(i_addr - `GPP_MIR_BASE) : i_addr;
	wire [7:0] mir_map = (reg_off == 8'h01 && i_addr >= `GPP_MIR_BASE) ?
		`GPP_OUT : (reg_off == 8'h02 && i_addr >= `GPP_MIR_BASE) ?
		`GPP_IN : (reg_off == 8'h03 && i_addr >= `GPP_MIR_BASE) ?
		`GPP_FLAGS : reg_off;
	wire w_dir = i_wr && mir_map == `GPP_DIR;
	wire w_out = i_wr && mir_map == `GPP_OUT;
	wire w_in = i_wr && mir_map == `GPP_IN;
	wire w_flags = i_wr && mir_map == `GPP_FLAGS;

	// ************************************************************
	// direction and drive level
	// ************************************************************
	always @(posedge i_clk) begin
		if (i_rst) begin
			dir_q <= `GPP_REG_RESET;
			out_q <= `GPP_REG_RESET;
		end else if (i_wr) begin
			if (w_dir)
				dir_q <= i_wdata[NPIN-1:0];
			if (i_addr == `GPP_DIR_SET)
				dir_q <= dir_q | i_wdata[NPIN-1:0];
			if (i_addr == `GPP_DIR_CLR)
				dir_q <= dir_q & ~i_wdata[NPIN-1:0];
			if (i_addr == `GPP_DIR_TGL)
				dir_q <= dir_q ^ i_wdata[NPIN-1:0];
			if (w_out)
				out_q <= i_wdata[NPIN-1:0];
			if (i_addr == `GPP_OUT_SET)
				out_q <= out_q | i_wdata[NPIN-1:0];
			if (i_addr == `GPP_OUT_CLR)
				out_q <= out_q & ~i_wdata[NPIN-1:0];
			if (i_addr == `GPP_OUT_TGL || w_in)
				out_q <= out_q ^ i_wdata[NPIN-1:0];
		end
	end

	// ************************************************************
	// per pin configuration, sensing and flags
	// ************************************************************
	genvar n;
	generate
		for (n = 0; n < NPIN; n = n + 1) begin : g_pin
			wire [2:0] sense = cfg_q[n][`GPP_CFG_SENSE_HI:`GPP_CFG_SENSE_LO];
			wire w_cfg = i_wr && i_addr == `GPP_CFG_BASE + n;
			reg [1:0] dead_q;
			assign inv[n] = cfg_q[n][`GPP_CFG_INV];
			assign in_en[n] = sense != `GPP_SENSE_INDIS;
			assign sense_en[n] = sense != `GPP_SENSE_INTDIS && in_en[n];
			// pull-up enable straight from the configuration byte
			assign o_pullup[n] = cfg_q[n][`GPP_CFG_PULL];
			// configuration byte; a sense change drops a pending edge
			always @(posedge i_clk) begin
				if (i_rst)
					cfg_q[n] <= `GPP_CFG_RESET;
				else if (w_cfg)
					cfg_q[n] <= i_wdata;
			end
			// synchroniser held while input disabled, keeps state
			always @(posedge i_clk) begin
				if (i_rst) begin
					sync1_q[n] <= 1'b0;
					sync2_q[n] <= 1'b0;
				end else if (in_en[n]) begin
					sync1_q[n] <= i_pad[n];
					sync2_q[n] <= sync1_q[n];
				end
			end
			// sensed value includes inversion so its change is an edge
			assign in_val[n] = sync2_q[n] ^ inv[n];
			// edge detection; prev held while disabled keeps pending edge
			assign hit[n] = !(w_cfg && (i_wdata[`GPP_CFG_SENSE_HI:0] != sense))
				&& sense_en[n] && (
				(sense == `GPP_SENSE_ANY && in_val[n] != prev_q[n]) ||
				(sense == `GPP_SENSE_RISE && in_val[n] && !prev_q[n]) ||
				(sense == `GPP_SENSE_FALL && !in_val[n] && prev_q[n]) ||
				(sense == `GPP_SENSE_LOW && !in_val[n]));
			assign dead[n] = !ASYNC_PINS[n] && dead_q != 2'h0;
			assign set_hit[n] = hit[n] && !dead[n];
			// dead-time counter after an accepted interrupt
			always @(posedge i_clk) begin
				if (i_rst)
					dead_q <= 2'h0;
				else if (set_hit[n])
					dead_q <= `GPP_DEAD_CYCLES;
				else if (dead_q != 2'h0)
					dead_q <= dead_q - 2'h1;
			end
			// previous value and pending mark
			always @(posedge i_clk) begin
				if (i_rst) begin
					prev_q[n] <= 1'b0;
					pend_q[n] <= 1'b0;
				end else if (in_en[n]) begin
					prev_q[n] <= in_val[n];
					pend_q[n] <= hit[n];
				end
			end
			// flag: set wins over clear by writing one
			always @(posedge i_clk) begin
				if (i_rst)
					flag_q[n] <= 1'b0;
				else if (set_hit[n])
					flag_q[n] <= 1'b1;
				else if (w_flags && i_wdata[n])
					flag_q[n] <= 1'b0;
			end
			// wake: async pins any sense; others edges-both or level while clock stopped, else any sense
			assign wake_pin[n] = sense_en[n] && (ASYNC_PINS[n] ||
				!i_sleep_clk_stopped || sense == `GPP_SENSE_ANY ||
				sense == `GPP_SENSE_LOW) && (hit[n] || pend_q[n]);
		end
	endgenerate

	// ************************************************************
	// pad drive and outputs
	// ************************************************************
	// drive level inverted by inversion bit; oe low while driving
	assign o_pad = out_q ^ inv;
	assign o_pad_oe_n = ~dir_q;
	assign o_inbuf_en = in_en;
	assign o_event = in_val & in_en;
	assign o_irq = |(flag_q & sense_en);
	assign o_wake = |wake_pin;

	// ************************************************************
	// read data, one cycle after the strobe; no debug dependence
	// ************************************************************
	always @(posedge i_clk) begin
		if (i_rst)
			o_rdata <= 8'h00;
		else if (i_rd) begin
			o_rdata <= 8'h00;
			case (mir_map)
			`GPP_DIR, `GPP_DIR_SET, `GPP_DIR_CLR, `GPP_DIR_TGL:
				o_rdata[NPIN-1:0] <= dir_q;
			`GPP_OUT, `GPP_OUT_SET, `GPP_OUT_CLR, `GPP_OUT_TGL:
				o_rdata[NPIN-1:0] <= out_q;
			`GPP_IN:
				o_rdata[NPIN-1:0] <= in_val;
			`GPP_FLAGS:
				o_rdata[NPIN-1:0] <= flag_q;
			default: begin
				if (i_addr >= `GPP_CFG_BASE && i_addr < `GPP_CFG_BASE + NPIN)
					o_rdata <= cfg_q[i_addr[2:0]];
			end
			endcase
		end
	end

endmodule // gpp_port
`default_nettype wire

// file: core/gpp_map.vh
// register map and field layout of the gpio pin port
`ifndef GPP_MAP_VH
`define GPP_MAP_VH
`define GPP_DIR 8'h00
`define GPP_DIR_SET 8'h01
`define GPP_DIR_CLR 8'h02
`define GPP_DIR_TGL 8'h03
`define GPP_OUT 8'h04
`define GPP_OUT_SET 8'h05
`define GPP_OUT_CLR 8'h06
`define GPP_OUT_TGL 8'h07
`define GPP_IN 8'h08
`define GPP_FLAGS 8'h09
`define GPP_CFG_BASE 8'h10
`define GPP_MIR_BASE 8'h20
`define GPP_WAKE_CTL 8'h30
`define GPP_CFG_INV 7
`define GPP_CFG_PULL 3
`define GPP_CFG_SENSE_HI 2
`define GPP_CFG_SENSE_LO 0
`define GPP_CFG_RESET 8'h00
`define GPP_REG_RESET 8'h00
`define GPP_SENSE_INTDIS 3'h0
`define GPP_SENSE_ANY 3'h1
`define GPP_SENSE_RISE 3'h2
`define GPP_SENSE_FALL 3'h3
`define GPP_SENSE_INDIS 3'h4
`define GPP_SENSE_LOW 3'h5
`define GPP_DEAD_CYCLES 2'h3
`endif

// file: bench/gpp_pads.sv
// pad and board model for the gpio pin port
`timescale 1ns/1ns
`default_nettype none
module gpp_pads (
	// port side
	input wire logic [7:0] i_drv,
	input wire logic [7:0] i_oe_n,
	// board side
	input wire logic [7:0] i_ext,
	output logic [7:0] o_lvl
);
	// an enabled driver wins, otherwise the board level shows
	assign o_lvl = (~i_oe_n & i_drv) | (i_oe_n & i_ext);
endmodule // gpp_pads
`default_nettype wire

// file: bench/gpp_port_chk.sv
// assertion checker for the gpio pin port
`timescale 1ns/1ns
`default_nettype none
module gpp_chk #(parameter NPIN = 8) (
	// clock, reset, register port
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// pads and status
	input wire logic [NPIN-1:0] o_pad,
	input wire logic [NPIN-1:0] o_pad_oe_n,
	input wire logic [NPIN-1:0] o_pullup,
	input wire logic [NPIN-1:0] o_inbuf_en,
	input wire logic [NPIN-1:0] o_event,
	input wire logic o_irq
);
	// ****************
	// port properties
	// ****************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_rst;
		$fell(i_rst) |-> o_pad_oe_n == '1 && o_inbuf_en == '1;
	endproperty
	a_rst: assert property (p_rst) else $error("pads not idle");
	property p_dset;
		i_wr && i_addr == 8'h01 |=> o_pad_oe_n == ($past(o_pad_oe_n) & ~$past(i_wdata));
	endproperty
	a_dset: assert property (p_dset) else $error("dir set");
	property p_dclr;
		i_wr && i_addr == 8'h02 |=> o_pad_oe_n == ($past(o_pad_oe_n) | $past(i_wdata));
	endproperty
	a_dclr: assert property (p_dclr) else $error("dir clear");
	property p_dtgl;
		i_wr && i_addr == 8'h03 |=> o_pad_oe_n == ($past(o_pad_oe_n) ^ $past(i_wdata));
	endproperty
	a_dtgl: assert property (p_dtgl) else $error("dir toggle");
	property p_otgl;
		i_wr && (i_addr == 8'h07 || i_addr == 8'h08) |=> o_pad == ($past(o_pad) ^ $past(i_wdata));
	endproperty
	a_otgl: assert property (p_otgl) else $error("out toggle");
	property p_rdir;
		i_rd && i_addr == 8'h01 |=> o_rdata == ~o_pad_oe_n;
	endproperty
	a_rdir: assert property (p_rdir) else $error("dir set read");
	property p_pull;
		i_wr && i_addr[7:3] == 5'h02 |=> o_pullup[$past(i_addr[2:0])] == $past(i_wdata[3]);
	endproperty
	a_pull: assert property (p_pull) else $error("pullup");
	property p_evt;
		(o_event & ~o_inbuf_en) == '0;
	endproperty
	a_evt: assert property (p_evt) else $error("event gate");
	property p_irq;
		o_irq && !i_wr |=> o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq dropped");
	c_irq: cover property ($rose(o_irq));
	c_fall_irq: cover property ($fell(o_irq));
	c_rdir: cover property (i_rd && i_addr == 8'h01);
	c_dis: cover property (o_inbuf_en != '1);
endmodule // gpp_chk
bind gpp_port gpp_chk #(.NPIN(NPIN)) i_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_pad(o_pad), .o_pad_oe_n(o_pad_oe_n),
	.o_pullup(o_pullup), .o_inbuf_en(o_inbuf_en), .o_event(o_event),
	.o_irq(o_irq));
`default_nettype wire

// file: bench/gpio_pin_port_bench.sv
// self-checking testbench for the gpio pin port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module gpio_pin_port_bench;
	logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic sleep = 1'b0;
	wire wake;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, ext = 8'h44;
	wire [7:0] rdata, lvl, drv, oe_n, pull, inb, evt;
	wire irq;
	int err_total = 0, checked = 0;
	// ****************
	// clock and blocks
	// ****************
	always #20 i_clk = ~i_clk;
	gpp_port i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.i_sleep_clk_stopped(sleep), .i_pad(lvl), .o_pad(drv),
		.o_pad_oe_n(oe_n), .o_pullup(pull), .o_inbuf_en(inb),
		.o_event(evt), .o_irq(irq), .o_wake(wake));
	gpp_pads i_pads (.i_drv(drv), .i_oe_n(oe_n), .i_ext(ext), .o_lvl(lvl));
	// register port access
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, e, input string n);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 `CHK(n, e, rdata)
	endtask
	// drive board level of pin 6 and let it settle
	task automatic pin6(input logic v);
		@(posedge i_clk);
		ext[6] <= v;
		repeat (6) @(posedge i_clk);
	endtask
	task print_verdict;
		if (err_total == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (3000) @(posedge i_clk);
		err_total++;
		print_verdict;
	end
	// test sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		#1 `CHK("oe_n", 8'hff, oe_n)
		`CHK("inbuf", 8'hff, inb)
		wr(8'h00, 8'h0f);
		wr(8'h01, 8'h30);
		rd(8'h01, 8'h3f, "dir_set");
		wr(8'h02, 8'h05);
		rd(8'h00, 8'h3a, "dir_clr");
		wr(8'h03, 8'h81);
		rd(8'h20, 8'hbb, "dir_mirror");
		`CHK("oe_n", 8'h44, oe_n)
		wr(8'h05, 8'h11);
		wr(8'h06, 8'h01);
		rd(8'h04, 8'h10, "out_clr");
		wr(8'h07, 8'h03);
		wr(8'h08, 8'h02);
		rd(8'h04, 8'h11, "out_tgl");
		wr(8'h21, 8'h10);
		rd(8'h05, 8'h10, "out_mirror");
		rd(8'h08, 8'h54, "in_val");
		wr(8'h14, 8'h80);
		`CHK("pad", 8'h00, drv)
		// the inverted drive needs two edges through the synchroniser
		repeat (3) @(posedge i_clk);
		rd(8'h22, 8'h54, "in_inv");
		wr(8'h12, 8'h04);
		`CHK("inbuf", 8'hfb, inb)
		`CHK("evt", 8'h00, evt & 8'h04)
		for (int s = 1; s < 6; s++) if (s != 4) begin
			pin6(1'b1);
			wr(8'h16, 8'h08 | s[7:0]);
			`CHK("pull", 8'h40, pull)
			wr(8'h09, 8'hff);
			pin6(1'b0);
			rd(8'h09, (s != 2) ? 8'h40 : 8'h00, "flag_fall");
			`CHK("irq", (s != 2), irq)
			wr(8'h23, 8'h40);
			pin6(1'b1);
			rd(8'h09, (s != 3) ? 8'h40 : 8'h00, "flag_rise");
		end
		`CHK("evt", 8'h40, evt & 8'h40)
		// clock-stopped sleep: pin 6 wakes on low level, not on falling
		@(posedge i_clk);
		sleep <= 1'b1;
		pin6(1'b0);
		#1 `CHK("wake_low", 1'b1, wake)
		wr(8'h16, 8'h03);
		`CHK("wake_fall", 1'b0, wake)
		print_verdict;
	end
endmodule // gpio_pin_port_bench
`default_nettype wire
